// >>> rtl/asp_pkg.sv
// Package: constants and carriers for the asynchronous SRAM port host controller
package asp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH  = 2048;

    // ------------------------------------------------------------
    // Timing in ns, as printed for the fastest grade
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS                = 40;
    localparam int unsigned ADDRESS_ACCESS_TIME_NS       = 70;
    localparam int unsigned SELECT_ACCESS_TIME_NS        = 70;
    localparam int unsigned OUTPUT_ENABLE_ACCESS_TIME_NS = 35;
    localparam int unsigned WRITE_PULSE_NS               = 55;
    localparam int unsigned WRITE_DATA_SETUP_NS          = 30;
    localparam int unsigned WRITE_DATA_HOLD_NS           = 5;
    localparam int unsigned SELECT_RECOVERY_TIME_NS      = 10;
    localparam int unsigned WRITE_TO_FLOAT_DELAY_NS      = 25;
    localparam int unsigned CYCLE_TIME_NS                = 70;

    // Least times round up
    localparam int unsigned RD_ACCESS_CYC =
        (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WR_PULSE_CYC0 =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC =
        (WRITE_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WR_PULSE_CYC = (WR_PULSE_CYC0 > SETUP_CYC) ? WR_PULSE_CYC0 : SETUP_CYC;
    localparam int unsigned HOLD_CYC =
        (WRITE_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVERY_CYC =
        (SELECT_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLOAT_CYC =
        (WRITE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asp_req_s;

    typedef struct packed {
        logic              select_n;
        logic              out_enable_n;
        logic              write_n;
        logic [ADDR_W-1:0] addr;
    } asp_strobe_s;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RD_WAIT = 3'b001,
        ST_WR_SET  = 3'b010,
        ST_WR_HOLD = 3'b011,
        ST_RECOVER = 3'b100
    } asp_state_e;

endpackage

// >>> rtl/asp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module asp_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // Pin side
    input  wire logic [WIDTH-1:0] async_i,
    // Core side
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
        end else begin
            meta_q <= async_i;
            s2_q   <= meta_q;
            s3_q   <= s2_q;
        end
    end

    // A bit changes only when second and third stages agree
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_o <= '0;
        end else begin
            for (int i = 0; i < int'(WIDTH); i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// >>> rtl/asp_host.sv
// Host bus master that drives a byte-wide asynchronous SRAM port
//
// Operation
// - Host keeps address stable for the whole write cycle.
// - Host holds strobe high for recovery time before the next cycle.
// - Host sets write data up before write end, holds after it.
// - Host keeps output enable high during writes.
`timescale 1ns/1ps
module asp_host (
    // Clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_i,
    // User request
    input  wire logic                       req_valid_i,
    input  wire asp_pkg::asp_req_s          req_i,
    output logic                            req_ready_o,
    // User answer
    output logic                            rsp_valid_o,
    output logic [asp_pkg::DATA_W-1:0]      rsp_rdata_o,
    output logic                            rsp_write_o,
    // Supply status
    input  wire logic                       power_fail_i,
    output logic                            power_fail_o,
    // SRAM pins
    output logic [asp_pkg::ADDR_W-1:0]      sram_addr_o,
    output logic                            sram_select_n_o,
    output logic                            sram_out_enable_n_o,
    output logic                            sram_write_n_o,
    input  wire logic [asp_pkg::DATA_W-1:0] data_io_lines_i,
    output logic [asp_pkg::DATA_W-1:0]      data_io_lines_o,
    output logic                            data_io_lines_oe_o
);

    asp_pkg::asp_state_e                state_q;
    logic [asp_pkg::CNT_W-1:0]          cnt_q;
    asp_pkg::asp_req_s                  cur_q;
    asp_pkg::asp_strobe_s               pins_q;
    logic [asp_pkg::DATA_W-1:0]         rd_sync;
    logic                               pf_sync;

    function automatic logic [asp_pkg::CNT_W-1:0] cyc(input int unsigned n);
        cyc = asp_pkg::CNT_W'(n - 1);
    endfunction

    // ------------------------------------------------------------
    // Pin input crossing
    // ------------------------------------------------------------
    // Read data is launched by the device with no clock, so it is synchronised.
    // Four extra cycles of access latency are the price of a clean capture.
    asp_sync #(
        .WIDTH (asp_pkg::DATA_W + 1)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({power_fail_i, data_io_lines_i}),
        .sync_o     ({pf_sync, rd_sync})
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= asp_pkg::ST_IDLE;
            cnt_q   <= '0;
            cur_q   <= '0;
        end else begin
            unique case (state_q)
                asp_pkg::ST_IDLE: begin
                    if (req_valid_i && !pf_sync) begin
                        cur_q <= req_i;
                        if (req_i.write) begin
                            state_q <= asp_pkg::ST_WR_SET;
                            cnt_q   <= cyc(asp_pkg::WR_PULSE_CYC);
                        end else begin
                            // Three sync stages plus the agreement stage sit on top of the access time
                            state_q <= asp_pkg::ST_RD_WAIT;
                            cnt_q   <= cyc(asp_pkg::RD_ACCESS_CYC + 4);
                        end
                    end
                end
                asp_pkg::ST_RD_WAIT: begin
                    if (cnt_q == '0) begin
                        state_q <= asp_pkg::ST_RECOVER;
                        cnt_q   <= cyc(asp_pkg::RECOVERY_CYC);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                asp_pkg::ST_WR_SET: begin
                    if (cnt_q == '0) begin
                        state_q <= asp_pkg::ST_WR_HOLD;
                        cnt_q   <= cyc(asp_pkg::HOLD_CYC);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                asp_pkg::ST_WR_HOLD: begin
                    if (cnt_q == '0) begin
                        state_q <= asp_pkg::ST_RECOVER;
                        cnt_q   <= cyc(asp_pkg::RECOVERY_CYC);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                asp_pkg::ST_RECOVER: begin
                    if (cnt_q == '0) begin
                        state_q <= asp_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= asp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strobe pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pins_q <= '{select_n: 1'b1, out_enable_n: 1'b1, write_n: 1'b1, addr: '0};
        end else begin
            unique case (state_q)
                asp_pkg::ST_IDLE: begin
                    if (req_valid_i && !pf_sync) begin
                        pins_q.addr         <= req_i.addr;
                        pins_q.select_n     <= 1'b0;
                        pins_q.write_n      <= !req_i.write;
                        pins_q.out_enable_n <= req_i.write;
                    end
                end
                asp_pkg::ST_WR_SET: begin
                    if (cnt_q == '0) begin
                        // Earlier rising edge ends the write
                        pins_q.write_n <= 1'b1;
                    end
                end
                asp_pkg::ST_WR_HOLD: begin
                    if (cnt_q == '0) begin
                        pins_q.select_n <= 1'b1;
                    end
                end
                asp_pkg::ST_RD_WAIT: begin
                    if (cnt_q == '0) begin
                        pins_q.select_n     <= 1'b1;
                        pins_q.out_enable_n <= 1'b1;
                    end
                end
                asp_pkg::ST_RECOVER: begin
                    pins_q.select_n <= 1'b1;
                end
                default: begin
                    pins_q.select_n <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data bus drive
    // ------------------------------------------------------------
    // Host drives only with output enable high, so the bus never fights.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_io_lines_o    <= '0;
            data_io_lines_oe_o <= 1'b0;
        end else if (state_q == asp_pkg::ST_IDLE && req_valid_i && !pf_sync && req_i.write) begin
            data_io_lines_o    <= req_i.wdata;
            data_io_lines_oe_o <= 1'b1;
        end else if (state_q == asp_pkg::ST_WR_HOLD && cnt_q == '0) begin
            data_io_lines_oe_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
            rsp_write_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            if (state_q == asp_pkg::ST_RD_WAIT && cnt_q == '0) begin
                rsp_valid_o <= 1'b1;
                rsp_rdata_o <= rd_sync;
                rsp_write_o <= 1'b0;
            end else if (state_q == asp_pkg::ST_WR_HOLD && cnt_q == '0) begin
                rsp_valid_o <= 1'b1;
                rsp_write_o <= 1'b1;
            end
        end
    end

    // Ready stays low under power fail, since the device ignores inputs then
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_ready_o  <= 1'b0;
            power_fail_o <= 1'b0;
        end else begin
            power_fail_o <= pf_sync;
            req_ready_o  <= (state_q == asp_pkg::ST_RECOVER && cnt_q == '0 && !pf_sync)
                         || (state_q == asp_pkg::ST_IDLE && !req_valid_i && !pf_sync);
        end
    end

    assign sram_addr_o         = pins_q.addr;
    assign sram_select_n_o     = pins_q.select_n;
    assign sram_out_enable_n_o = pins_q.out_enable_n;
    assign sram_write_n_o      = pins_q.write_n;

endmodule

// >>> verification/asp_host_chk.sv
// Checker: host-side strobe ordering on the SRAM pins
`timescale 1ns/1ps
module asp_host_chk (
    // Clock and reset
    input wire logic                       core_clk_i,
    input wire logic                       reset_i,
    // Watched ports
    input wire logic                       rsp_valid_o,
    input wire logic                       rsp_write_o,
    input wire logic                       power_fail_o,
    input wire logic [asp_pkg::ADDR_W-1:0] sram_addr_o,
    input wire logic                       sram_select_n_o,
    input wire logic                       sram_out_enable_n_o,
    input wire logic                       sram_write_n_o,
    input wire logic [asp_pkg::DATA_W-1:0] data_io_lines_o,
    input wire logic                       data_io_lines_oe_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    addr_stable_a: assert property (!sram_select_n_o && !$past(sram_select_n_o) |-> $stable(sram_addr_o))
        else $error("address moved under select");
    select_recover_a: assert property ($rose(sram_select_n_o) |=> sram_select_n_o)
        else $error("select recovery too short");
    write_setup_a: assert property ($fell(sram_write_n_o) |-> data_io_lines_oe_o
        ##1 (!sram_write_n_o && $stable(data_io_lines_o)) ##1 (sram_write_n_o && $stable(data_io_lines_o)))
        else $error("write pulse or data setup wrong");
    write_hold_a: assert property ($rose(sram_write_n_o) |-> data_io_lines_oe_o
        ##1 (sram_select_n_o && !data_io_lines_oe_o && rsp_valid_o && rsp_write_o))
        else $error("write data hold or end wrong");
    oe_in_write_a: assert property (!sram_write_n_o |-> sram_out_enable_n_o)
        else $error("output enable low during write");
    no_fight_a: assert property (!sram_out_enable_n_o |-> !data_io_lines_oe_o)
        else $error("both sides drive the data bus");
    read_wait_a: assert property ($fell(sram_out_enable_n_o) |->
        (!sram_out_enable_n_o && !sram_select_n_o && sram_write_n_o) [*6]
        ##1 (sram_out_enable_n_o && rsp_valid_o && !rsp_write_o))
        else $error("read cycle shape wrong");
    pf_idle_a: assert property (sram_select_n_o ##1 power_fail_o |-> sram_select_n_o)
        else $error("cycle started under power fail");

    cover property ($rose(sram_write_n_o));
    cover property (rsp_valid_o && !rsp_write_o);
    cover property (power_fail_o && sram_select_n_o);
endmodule

bind asp_host asp_host_chk chk_u (.core_clk_i, .reset_i, .rsp_valid_o, .rsp_write_o, .power_fail_o,
    .sram_addr_o, .sram_select_n_o, .sram_out_enable_n_o, .sram_write_n_o, .data_io_lines_o,
    .data_io_lines_oe_o);

// >>> verification/asp_sram_model.sv
// Behavioural model of the battery-backed byte-wide SRAM device
`timescale 1ns/1ps
module asp_sram_model (
    // Strobes
    input  wire logic [asp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       select_n_i,
    input  wire logic                       out_enable_n_i,
    input  wire logic                       write_n_i,
    // Supply
    input  wire logic                       power_fail_i,
    input  wire logic                       battery_low_i,
    // Data bus
    input  wire logic [asp_pkg::DATA_W-1:0] data_i,
    output logic      [asp_pkg::DATA_W-1:0] data_o
);
    logic [asp_pkg::DATA_W-1:0] mem [asp_pkg::DEPTH];
    logic                       battery_low_flag;
    logic                       wr_act;
    realtime                    t_a, t_s, t_g;

    initial begin
        battery_low_flag = 1'b0;
        wr_act = 1'b0;
        data_o = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
    end
    always @(addr_i) t_a = $realtime;
    always @(negedge select_n_i) t_s = $realtime;
    always @(negedge out_enable_n_i) t_g = $realtime;

    // Unknown settles to a toggling pattern so a stale byte can never pass
    always #1 begin
        if (!power_fail_i && !select_n_i && !out_enable_n_i && write_n_i
            && $realtime - t_a >= asp_pkg::ADDRESS_ACCESS_TIME_NS
            && $realtime - t_s >= asp_pkg::SELECT_ACCESS_TIME_NS
            && $realtime - t_g >= asp_pkg::OUTPUT_ENABLE_ACCESS_TIME_NS)
            data_o = mem[addr_i];
        else
            data_o = ~data_o;
    end

    always @(select_n_i or write_n_i or power_fail_i) begin
        if (!select_n_i && !write_n_i && !power_fail_i) begin
            wr_act = 1'b1;
        end else if (wr_act) begin
            wr_act = 1'b0;
            if (!power_fail_i && battery_low_flag)
                battery_low_flag = 1'b0;
            else if (!power_fail_i)
                mem[addr_i] = data_i;
        end
    end

    always @(negedge power_fail_i) battery_low_flag = battery_low_i;
endmodule

// >>> verification/asp_host_tb_top.sv
// Testbench: host controller against the behavioural SRAM device
`timescale 1ns/1ps
module asp_host_tb_top;
    logic                       core_clk_i, reset_i, req_valid_i, power_fail_i, battery_low;
    asp_pkg::asp_req_s          req_i;
    logic                       req_ready_o, rsp_valid_o, rsp_write_o, power_fail_o;
    logic                       sram_select_n_o, sram_out_enable_n_o, sram_write_n_o, data_io_lines_oe_o;
    logic [asp_pkg::DATA_W-1:0] rsp_rdata_o, data_io_lines_i, data_io_lines_o, dev_data;
    logic [asp_pkg::ADDR_W-1:0] sram_addr_o;
    int                         num_errors, tests_run;

    // Host driver wins only while its enable is up
    assign data_io_lines_i = data_io_lines_oe_o ? data_io_lines_o : dev_data;

    asp_host dut_u (.core_clk_i, .reset_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o,
        .rsp_write_o, .power_fail_i, .power_fail_o, .sram_addr_o, .sram_select_n_o, .sram_out_enable_n_o,
        .sram_write_n_o, .data_io_lines_i, .data_io_lines_o, .data_io_lines_oe_o);
    asp_sram_model dev_u (.addr_i(sram_addr_o), .select_n_i(sram_select_n_o), .out_enable_n_i(sram_out_enable_n_o),
        .write_n_i(sram_write_n_o), .power_fail_i, .battery_low_i(battery_low), .data_i(data_io_lines_i),
        .data_o(dev_data));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Request is held until the select falls, since ready is only advisory
    task automatic op(input logic wr, input logic [10:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic got);
        got = 1'b0;
        q = 8'h00;
        @(posedge core_clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{write: wr, addr: a, wdata: d};
        for (int n = 0; n < 20 && !got; n++) begin
            @(posedge core_clk_i);
            if (sram_select_n_o === 1'b0) req_valid_i <= 1'b0;
            if (rsp_valid_o === 1'b1) begin
                got = 1'b1;
                q = rsp_rdata_o;
                check(rsp_write_o, wr);
            end
        end
        req_valid_i <= 1'b0;
    endtask

    task automatic t_rw();
        logic [10:0] a [3] = '{11'h000, 11'h7ff, 11'h2aa};
        logic [7:0]  d [3] = '{8'ha5, 8'h3c, 8'h5a};
        logic [7:0]  q;
        logic        got;
        for (int i = 0; i < 3; i++) begin
            op(1'b1, a[i], d[i], q, got);
            check(got, 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            op(1'b0, a[i], 8'h00, q, got);
            check(q, d[i]);
        end
    endtask

    task automatic t_pf();
        logic [7:0] q;
        logic       got;
        power_fail_i <= 1'b1;
        battery_low <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        op(1'b1, 11'h2aa, 8'h00, q, got);
        check(got, 1'b0);
        check(req_ready_o, 1'b0);
        check(power_fail_o, 1'b1);
        power_fail_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(req_ready_o, 1'b1);
        battery_low <= 1'b0;
        op(1'b1, 11'h2aa, 8'h11, q, got);
        op(1'b0, 11'h2aa, 8'h00, q, got);
        check(q, 8'h5a);
        op(1'b1, 11'h2aa, 8'h22, q, got);
        op(1'b0, 11'h2aa, 8'h00, q, got);
        check(q, 8'h22);
        op(1'b0, 11'h000, 8'h00, q, got);
        check(q, 8'ha5);
    endtask

    // Supply drops on the same edge that starts a write; other bytes must survive
    task automatic t_cut();
        logic [7:0] q;
        logic       got;
        fork
            op(1'b1, 11'h7ff, 8'h77, q, got);
            begin
                repeat (2) @(posedge core_clk_i);
                power_fail_i <= 1'b1;
            end
        join
        repeat (8) @(posedge core_clk_i);
        power_fail_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        op(1'b0, 11'h000, 8'h00, q, got);
        check(q, 8'ha5);
        op(1'b0, 11'h2aa, 8'h00, q, got);
        check(q, 8'h22);
    endtask

    initial begin
        num_errors = 0;
        tests_run = 0;
        battery_low = 1'b0;
        power_fail_i = 1'b0;
        reset_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_rw();
        t_pf();
        t_cut();
        print_verdict();
    end

    // Whole run needs about a hundred and seventy cycles
    initial begin
        repeat (3000) @(posedge core_clk_i);
        num_errors++;
        print_verdict();
    end
endmodule
